//--- verilog/desc_pkg.sv
package desc_pkg;
	// Descriptor types seen in the request's high value byte
	localparam logic [7:0] TYPE_STRING       = 8'h03;
	localparam logic [7:0] TYPE_INTERFACE    = 8'h04;
	localparam logic [7:0] TYPE_ENDPOINT     = 8'h05;
	localparam logic [7:0] TYPE_QUALIFIER    = 8'h06;
	localparam logic [7:0] TYPE_OTHER_SPEED  = 8'h07;
	// Other-speed configuration fixed fields and defaults
	localparam logic [7:0]  OSC_LENGTH       = 8'h09;
	localparam logic [15:0] OSC_TOTAL_LENGTH = 16'h0027;
	localparam logic [7:0]  OSC_NUM_IF       = 8'h01;
	localparam logic [7:0]  OSC_CFG_VALUE    = 8'h01;
	localparam logic [7:0]  OSC_CFG_STR_DEF  = 8'h00;
	localparam logic [7:0]  OSC_ATTR_DEF     = 8'hA0;
	localparam logic [7:0]  OSC_ATTR_WAKE    = 8'h20;
	localparam logic [7:0]  OSC_POWER_SELF   = 8'h01;
	localparam logic [7:0]  OSC_POWER_BUS    = 8'hFA;
	// Device qualifier fields
	localparam logic [7:0]  DQ_LENGTH        = 8'h0A;
	localparam logic [15:0] DQ_BCD_USB       = 16'h0200;
	localparam logic [7:0]  DQ_CLASS         = 8'hFF;
	localparam logic [7:0]  DQ_SUBCLASS      = 8'h00;
	localparam logic [7:0]  DQ_PROTOCOL      = 8'hFF;
	localparam logic [7:0]  DQ_MAX_PKT0      = 8'h40;
	localparam logic [7:0]  DQ_NUM_CFG       = 8'h01;
	localparam logic [7:0]  DQ_RESERVED      = 8'h00;
	// Language-ID string
	localparam logic [7:0]  LANGID_LENGTH    = 8'h04;
	localparam logic [7:0]  LANGID_EE_ADDR   = 8'h0A;
	localparam int          NUM_STRINGS      = 5;
endpackage : desc_pkg

//--- verilog/desc_fields_if.sv
interface desc_fields_if;
	// Opposite-speed field set handed from the selector to the streamer
	logic [7:0] cfg_string;
	logic [7:0] attributes;
	logic [7:0] max_power;
	logic [7:0] dev_class;
	logic [7:0] dev_subclass;
	logic [7:0] dev_protocol;

	modport source (output cfg_string, attributes, max_power, dev_class, dev_subclass,
		dev_protocol);
	modport sink   (input cfg_string, attributes, max_power, dev_class, dev_subclass,
		dev_protocol);
endinterface : desc_fields_if

//--- verilog/desc_field_select.sv
module desc_field_select (
	input  wire logic         high_speed_i,
	input  wire logic         ee_valid_i,
	input  wire logic         self_powered_i,
	input  wire logic         remote_wakeup_strap_i,
	input  wire logic [47:0]  ee_hs_fields_i,
	input  wire logic [47:0]  ee_fs_fields_i,
	desc_fields_if.source     fields
);
	logic [47:0] opp;

	// Opposite speed's settings feed both descriptors
	assign opp = high_speed_i ? ee_fs_fields_i : ee_hs_fields_i;

	// Defaults apply when no EEPROM is usable
	always_comb begin
		if (ee_valid_i) begin
			fields.cfg_string   = opp[7:0];
			fields.attributes   = opp[15:8];
			fields.max_power    = opp[23:16];
			fields.dev_class    = opp[31:24];
			fields.dev_subclass = opp[39:32];
			fields.dev_protocol = opp[47:40];
		end else begin
			fields.cfg_string   = desc_pkg::OSC_CFG_STR_DEF;
			fields.attributes   = remote_wakeup_strap_i ? desc_pkg::OSC_ATTR_DEF
				: (desc_pkg::OSC_ATTR_DEF & ~desc_pkg::OSC_ATTR_WAKE);
			fields.max_power    = self_powered_i ? desc_pkg::OSC_POWER_SELF
				: desc_pkg::OSC_POWER_BUS;
			fields.dev_class    = desc_pkg::DQ_CLASS;
			fields.dev_subclass = desc_pkg::DQ_SUBCLASS;
			fields.dev_protocol = desc_pkg::DQ_PROTOCOL;
		end
	end
endmodule // desc_field_select

//--- verilog/usb_desc_other_speed.sv
module usb_desc_other_speed (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         req_valid_i,
	input  wire logic [7:0]   req_type_i,
	input  wire logic [7:0]   req_index_i,
	input  wire logic [15:0]  req_langid_i,
	input  wire logic [15:0]  req_length_i,
	input  wire logic         high_speed_i,
	input  wire logic         self_powered_i,
	input  wire logic         remote_wakeup_strap_i,
	input  wire logic         ee_valid_i,
	input  wire logic [47:0]  ee_hs_fields_i,
	input  wire logic [47:0]  ee_fs_fields_i,
	input  wire logic [39:0]  ee_str_len_i,
	input  wire logic [39:0]  ee_str_off_i,
	output logic              ee_rd_o,
	output logic [7:0]        ee_addr_o,
	input  wire logic [7:0]   ee_data_i,
	input  wire logic         ee_ack_i,
	output logic              byte_valid_o,
	output logic [7:0]        byte_data_o,
	output logic              byte_last_o,
	input  wire logic         byte_ready_i,
	output logic              stall_o,
	output logic              busy_o
);
	typedef enum {IDLE, SEND, FETCH, WAIT_EE} state_t;

	desc_fields_if fields ();

	desc_field_select desc_field_select_inst (
		.high_speed_i          (high_speed_i),
		.ee_valid_i            (ee_valid_i),
		.self_powered_i        (self_powered_i),
		.remote_wakeup_strap_i (remote_wakeup_strap_i),
		.ee_hs_fields_i        (ee_hs_fields_i),
		.ee_fs_fields_i        (ee_fs_fields_i),
		.fields                (fields.source)
	);

	state_t      state, next_state;
	logic [7:0]  kind, next_kind;
	logic [7:0]  pos, next_pos;
	logic [7:0]  total, next_total;
	logic [7:0]  base, next_base;
	logic [7:0]  data, next_data;
	logic        stall, next_stall;
	logic        rom_src, next_rom_src;
	logic [7:0]  rom_byte;
	logic        any_string;
	logic [7:0]  str_len;
	logic [7:0]  str_off;

	// Internally generated bytes by position, words low byte first
	function automatic logic [7:0] rom_at(input logic [7:0] k, input logic [7:0] p,
		input logic [7:0] cs, input logic [7:0] at, input logic [7:0] mp,
		input logic [7:0] cl, input logic [7:0] sc, input logic [7:0] pr);
		logic [7:0] r;
		r = 8'h00;
		if (k == desc_pkg::TYPE_OTHER_SPEED) begin
			case (p)
				8'h00: r = desc_pkg::OSC_LENGTH;
				8'h01: r = desc_pkg::TYPE_OTHER_SPEED;
				8'h02: r = desc_pkg::OSC_TOTAL_LENGTH[7:0];
				8'h03: r = desc_pkg::OSC_TOTAL_LENGTH[15:8];
				8'h04: r = desc_pkg::OSC_NUM_IF;
				8'h05: r = desc_pkg::OSC_CFG_VALUE;
				8'h06: r = cs;
				8'h07: r = at;
				8'h08: r = mp;
				default: r = 8'h00;
			endcase
		end else if (k == desc_pkg::TYPE_QUALIFIER) begin
			case (p)
				8'h00: r = desc_pkg::DQ_LENGTH;
				8'h01: r = desc_pkg::TYPE_QUALIFIER;
				8'h02: r = desc_pkg::DQ_BCD_USB[7:0];
				8'h03: r = desc_pkg::DQ_BCD_USB[15:8];
				8'h04: r = cl;
				8'h05: r = sc;
				8'h06: r = pr;
				8'h07: r = desc_pkg::DQ_MAX_PKT0;
				8'h08: r = desc_pkg::DQ_NUM_CFG;
				default: r = desc_pkg::DQ_RESERVED;
			endcase
		end else begin
			r = (p == 8'h00) ? desc_pkg::LANGID_LENGTH : desc_pkg::TYPE_STRING;
		end
		return r;
	endfunction

	// Per-index string table lookup; index 0 never gets here
	assign str_len    = (req_index_i >= 8'h01 && req_index_i <= 8'h05)
		? ee_str_len_i[8*(req_index_i-8'h01) +: 8] : 8'h00;
	assign str_off    = (req_index_i >= 8'h01 && req_index_i <= 8'h05)
		? ee_str_off_i[8*(req_index_i-8'h01) +: 8] : 8'h00;
	assign any_string = |ee_str_len_i;
	assign rom_byte   = rom_at(kind, pos, fields.cfg_string, fields.attributes,
		fields.max_power, fields.dev_class, fields.dev_subclass, fields.dev_protocol);

	// Request decode and byte stream sequencing
	always_comb begin
		next_state   = state;
		next_kind    = kind;
		next_pos     = pos;
		next_total   = total;
		next_base    = base;
		next_data    = data;
		next_stall   = 1'b0;
		next_rom_src = rom_src;
		case (state)
			IDLE: begin
				if (req_valid_i) begin
					// Requested language ID never enters the decision
					next_kind = req_type_i;
					next_pos  = 8'h00;
					next_state = SEND;
					next_rom_src = 1'b1;
					if (req_type_i == desc_pkg::TYPE_OTHER_SPEED) begin
						next_total = desc_pkg::OSC_LENGTH;
					end else if (req_type_i == desc_pkg::TYPE_QUALIFIER) begin
						next_total = desc_pkg::DQ_LENGTH;
					end else if (req_type_i == desc_pkg::TYPE_STRING && req_index_i == 8'h00) begin
						next_total = desc_pkg::LANGID_LENGTH;
						next_base  = desc_pkg::LANGID_EE_ADDR - 8'h02;
						if (!ee_valid_i || !any_string) begin
							next_stall = 1'b1;
							next_state = IDLE;
						end
					end else if (req_type_i == desc_pkg::TYPE_STRING && req_index_i <= 8'h05) begin
						next_total   = str_len;
						next_base    = str_off;
						next_rom_src = 1'b0; // Raw EEPROM bytes
						if (!ee_valid_i || (str_len == 8'h00 && str_off == 8'h00)
							|| str_len == 8'h00) begin
							next_stall = 1'b1;
							next_state = IDLE;
						end
					end else begin
						next_stall = 1'b1; // Interface, endpoint, unknown
						next_state = IDLE;
					end
					// Truncate to the host's length
					if (next_state == SEND && {8'h00, next_total} > req_length_i) begin
						next_total = req_length_i[7:0];
					end
					if (next_state == SEND && next_total == 8'h00) begin
						next_state = IDLE;
					end
				end
			end
			SEND: begin
				// Langid payload beyond the header comes from EEPROM
				if (rom_src && (kind != desc_pkg::TYPE_STRING || pos < 8'h02)) begin
					next_data  = rom_byte;
					next_state = FETCH;
				end else begin
					next_state = WAIT_EE;
				end
			end
			WAIT_EE: begin
				if (ee_ack_i) begin
					next_data  = ee_data_i;
					next_state = FETCH;
				end
			end
			FETCH: begin
				if (byte_ready_i) begin
					next_pos   = pos + 8'h01;
					next_state = (pos + 8'h01 == total) ? IDLE : SEND;
				end
			end
			default: next_state = IDLE;
		endcase
	end

	// Only registering here; reset puts the stream idle
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state   <= IDLE;
			kind    <= 8'h00;
			pos     <= 8'h00;
			total   <= 8'h00;
			base    <= 8'h00;
			data    <= 8'h00;
			stall   <= 1'b0;
			rom_src <= 1'b0;
		end else begin
			state   <= next_state;
			kind    <= next_kind;
			pos     <= next_pos;
			total   <= next_total;
			base    <= next_base;
			data    <= next_data;
			stall   <= next_stall;
			rom_src <= next_rom_src;
		end
	end

	// Handshake outputs are decoded from state
	assign ee_rd_o      = (state == WAIT_EE);
	assign ee_addr_o    = base + pos;
	assign byte_valid_o = (state == FETCH);
	assign byte_data_o  = data;
	assign byte_last_o  = (state == FETCH) && (pos + 8'h01 == total);
	assign stall_o      = stall;
	assign busy_o       = (state != IDLE);

	// Stream checks; a stall must never leave the block busy
	a_stall_unsupported: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == IDLE && req_valid_i && (req_type_i == desc_pkg::TYPE_INTERFACE
		|| req_type_i == desc_pkg::TYPE_ENDPOINT) |=> stall_o && !busy_o)
		else $error("unsupported descriptor not stalled");
	a_stall_langid: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == IDLE && req_valid_i && req_type_i == desc_pkg::TYPE_STRING
		&& req_index_i == 8'h00 && !ee_valid_i |=> stall_o)
		else $error("langid without eeprom not stalled");
	a_stall_string: assert property (@(posedge clk_i) disable iff (!resetn_i)
		state == IDLE && req_valid_i && req_type_i == desc_pkg::TYPE_STRING
		&& req_index_i >= 8'h01 && req_index_i <= 8'h05 && !ee_valid_i |=> stall_o)
		else $error("string without eeprom not stalled");
	a_osc_first_byte: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o && pos == 8'h00 && kind == desc_pkg::TYPE_OTHER_SPEED
		|-> byte_data_o == 8'h09)
		else $error("other speed length byte wrong");
	a_osc_power: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o && pos == 8'h08 && kind == desc_pkg::TYPE_OTHER_SPEED
		&& !ee_valid_i |-> byte_data_o == (self_powered_i ? 8'h01 : 8'hFA))
		else $error("max power default wrong");
	a_osc_attr: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o && pos == 8'h07 && kind == desc_pkg::TYPE_OTHER_SPEED
		&& !ee_valid_i |-> byte_data_o[5] == remote_wakeup_strap_i)
		else $error("attributes wakeup bit ignores strap");
	a_dq_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o && pos == 8'h09 && kind == desc_pkg::TYPE_QUALIFIER
		|-> byte_data_o == 8'h00 && byte_last_o)
		else $error("qualifier reserved byte wrong");
	a_dq_bcd: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o && pos == 8'h03 && kind == desc_pkg::TYPE_QUALIFIER
		|-> byte_data_o == 8'h02)
		else $error("qualifier release high byte wrong");
	a_trunc_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
		byte_valid_o |-> pos < total)
		else $error("byte sent beyond length");
	a_langid_addr: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ee_rd_o && kind == desc_pkg::TYPE_STRING && rom_src
		|-> ee_addr_o == 8'h0A || ee_addr_o == 8'h0B)
		else $error("langid read from wrong address");
	a_ee_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ee_rd_o && !ee_ack_i |=> ee_rd_o && $stable(ee_addr_o))
		else $error("eeprom read dropped before acknowledge");
endmodule // usb_desc_other_speed

//--- sim/usb_host_ee_model.sv
module usb_host_ee_model (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       slow_i,
	input  wire logic       ee_rd_i,
	input  wire logic [7:0] ee_addr_i,
	output logic      [7:0] ee_data_o,
	output logic            ee_ack_o,
	output logic            byte_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Image loaded by the bench; holds language ID and raw strings
	logic [7:0] mem [256];
	logic [1:0] wait_cnt;

	// Read answer after a short or long wait; data bus wanders outside the ack
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ee_ack_o  <= 1'b0;
			ee_data_o <= 8'h00;
			wait_cnt  <= 2'h0;
		end else begin
			ee_ack_o  <= 1'b0;
			ee_data_o <= ~ee_data_o; // Stale value never looks valid
			if (ee_rd_i && !ee_ack_o) begin
				if (wait_cnt == (slow_i ? 2'h3 : 2'h0)) begin
					ee_ack_o  <= 1'b1;
					ee_data_o <= mem[ee_addr_i];
					wait_cnt  <= 2'h0;
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end
		end
	end

	// Host side accepts every byte, or every other cycle when slow
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_ready_o <= 1'b0;
		end else begin
			byte_ready_o <= slow_i ? ~byte_ready_o : 1'b1;
		end
	end
endmodule // usb_host_ee_model

//--- sim/usb_desc_other_speed_bench.sv
module usb_desc_other_speed_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] byte_q_t[$];
	logic        clk_i, resetn_i, req_valid_i, high_speed_i, self_powered_i;
	logic        remote_wakeup_strap_i, ee_valid_i, ee_rd_o, ee_ack_i, slow;
	logic [7:0]  req_type_i, req_index_i, ee_addr_o, ee_data_i, byte_data_o;
	logic [15:0] req_langid_i, req_length_i;
	logic [47:0] ee_hs_fields_i, ee_fs_fields_i;
	logic [39:0] ee_str_len_i, ee_str_off_i;
	logic        byte_valid_o, byte_last_o, byte_ready_i, stall_o, busy_o, stalled;
	byte_q_t     got;
	int          mismatches, n_tests, n_last, last_idx;

	usb_desc_other_speed usb_desc_other_speed_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.req_valid_i(req_valid_i), .req_type_i(req_type_i), .req_index_i(req_index_i),
		.req_langid_i(req_langid_i), .req_length_i(req_length_i),
		.high_speed_i(high_speed_i), .self_powered_i(self_powered_i),
		.remote_wakeup_strap_i(remote_wakeup_strap_i), .ee_valid_i(ee_valid_i),
		.ee_hs_fields_i(ee_hs_fields_i), .ee_fs_fields_i(ee_fs_fields_i),
		.ee_str_len_i(ee_str_len_i), .ee_str_off_i(ee_str_off_i), .ee_rd_o(ee_rd_o),
		.ee_addr_o(ee_addr_o), .ee_data_i(ee_data_i), .ee_ack_i(ee_ack_i),
		.byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
		.byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i), .stall_o(stall_o),
		.busy_o(busy_o));
	usb_host_ee_model usb_host_ee_model_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.slow_i(slow), .ee_rd_i(ee_rd_o), .ee_addr_i(ee_addr_o), .ee_data_o(ee_data_i),
		.ee_ack_o(ee_ack_i), .byte_ready_o(byte_ready_i));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Capture accepted bytes and stall pulses
	always @(posedge clk_i) begin
		if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
			if (byte_last_o === 1'b1) begin
				n_last++;
				last_idx = got.size();
			end
			got.push_back(byte_data_o);
		end
		if (stall_o === 1'b1) stalled = 1'b1;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One request, then wait for the block to go idle
	task automatic run(input logic [7:0] t, input logic [7:0] idx, input logic [15:0] len,
		input logic [15:0] lang);
		got.delete();
		stalled = 1'b0;
		n_last = 0;
		last_idx = -1;
		@(posedge clk_i);
		req_valid_i  <= 1'b1;
		req_type_i   <= t;
		req_index_i  <= idx;
		req_length_i <= len;
		req_langid_i <= lang;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_i);
			if (i > 1 && busy_o === 1'b0) break;
		end
		// A request that never finishes counts against the run
		if (busy_o !== 1'b0) begin
			mismatches++;
			$display("unexpected busy at end of request exp 0 seen %b", busy_o);
		end
	endtask

	task automatic check_bytes(input string what, input byte_q_t exp);
		n_tests++;
		if (stalled !== 1'b0 || got.size() != exp.size()) begin
			mismatches++;
			$display("unexpected %s length exp %0d seen %0d", what, exp.size(), got.size());
		end else begin
			foreach (exp[i]) if (got[i] !== exp[i]) begin
				mismatches++;
				$display("unexpected %s byte %0d exp %h seen %h", what, i, exp[i], got[i]);
			end
			// Last flag must mark the final byte only
			if (n_last != 1 || last_idx != exp.size() - 1) begin
				mismatches++;
				$display("unexpected %s last index exp %0d seen %0d", what, exp.size() - 1,
					last_idx);
			end
		end
	endtask

	task automatic check_stall(input string what);
		n_tests++;
		if (stalled !== 1'b1 || got.size() != 0) begin
			mismatches++;
			$display("unexpected %s stall exp 1 seen %b bytes %0d", what, stalled, got.size());
		end
	endtask

	// Defaults without an EEPROM, both power modes and strap levels
	task automatic t_defaults;
		ee_valid_i <= 1'b0;
		run(desc_pkg::TYPE_OTHER_SPEED, 8'h00, 16'h00FF, 16'h0000);
		check_bytes("osc", {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0, 8'h01});
		self_powered_i        <= 1'b0;
		remote_wakeup_strap_i <= 1'b0;
		run(desc_pkg::TYPE_OTHER_SPEED, 8'h00, 16'h0009, 16'h0000);
		check_bytes("osc_bus", {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'hFA});
		$display("test defaults done");
	endtask

	// EEPROM fields follow the opposite speed
	task automatic t_speeds;
		ee_valid_i <= 1'b1;
		run(desc_pkg::TYPE_OTHER_SPEED, 8'h00, 16'h00FF, 16'h0000);
		check_bytes("osc_hs", {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h03, 8'hC0, 8'h64});
		run(desc_pkg::TYPE_QUALIFIER, 8'h00, 16'h00FF, 16'h0000);
		check_bytes("dq_hs", {8'h0A, 8'h06, 8'h00, 8'h02, 8'hDC, 8'h01, 8'h02, 8'h40, 8'h01, 8'h00});
		high_speed_i <= 1'b0;
		run(desc_pkg::TYPE_OTHER_SPEED, 8'h00, 16'h00FF, 16'h0000);
		check_bytes("osc_fs", {8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, 8'h05, 8'hE0, 8'h32});
		run(desc_pkg::TYPE_QUALIFIER, 8'h00, 16'h0003, 16'h0000);
		check_bytes("dq_short", {8'h0A, 8'h06, 8'h00});
		run(desc_pkg::TYPE_INTERFACE, 8'h00, 16'h00FF, 16'h0000);
		check_stall("iface");
		run(desc_pkg::TYPE_ENDPOINT, 8'h00, 16'h00FF, 16'h0000);
		check_stall("endpoint");
		$display("test speeds done");
	endtask

	// Strings with slow EEPROM and a stalling host
	task automatic t_strings;
		slow <= 1'b1;
		run(desc_pkg::TYPE_STRING, 8'h00, 16'h00FF, 16'h0000);
		check_stall("langid_nolen");
		ee_str_len_i <= 40'h0000000600;
		ee_str_off_i <= 40'h0000002000;
		run(desc_pkg::TYPE_STRING, 8'h00, 16'h00FF, 16'h1234);
		check_bytes("langid", {8'h04, 8'h03, 8'h09, 8'h04});
		run(desc_pkg::TYPE_STRING, 8'h00, 16'h00FF, 16'h0409);
		check_bytes("langid_us", {8'h04, 8'h03, 8'h09, 8'h04});
		run(desc_pkg::TYPE_STRING, 8'h02, 16'h00FF, 16'h0409);
		check_bytes("str2", {8'h06, 8'h03, 8'h41, 8'h00, 8'h42, 8'h00});
		run(desc_pkg::TYPE_STRING, 8'h01, 16'h00FF, 16'h0409);
		check_stall("str1_empty");
		run(desc_pkg::TYPE_STRING, 8'h06, 16'h00FF, 16'h0409);
		check_stall("str6");
		ee_valid_i <= 1'b0;
		run(desc_pkg::TYPE_STRING, 8'h02, 16'h00FF, 16'h0409);
		check_stall("str2_noee");
		run(desc_pkg::TYPE_STRING, 8'h00, 16'h00FF, 16'h0409);
		check_stall("langid_noee");
		$display("test strings done");
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end

	// Main sequence
	initial begin
		mismatches = 0;
		n_tests = 0;
		{resetn_i, req_valid_i, ee_valid_i, slow} = 4'h0;
		{high_speed_i, self_powered_i, remote_wakeup_strap_i} = 3'h7;
		{req_type_i, req_index_i, req_langid_i, req_length_i} = 48'h0;
		ee_hs_fields_i = 48'hFF00FF32E005;
		ee_fs_fields_i = 48'h0201DC64C003;
		{ee_str_len_i, ee_str_off_i} = 80'h0;
		foreach (usb_host_ee_model_inst.mem[i]) usb_host_ee_model_inst.mem[i] = 8'h5A;
		usb_host_ee_model_inst.mem[8'h0A] = 8'h09;
		usb_host_ee_model_inst.mem[8'h0B] = 8'h04;
		{usb_host_ee_model_inst.mem[8'h20], usb_host_ee_model_inst.mem[8'h21]} = 16'h0603;
		{usb_host_ee_model_inst.mem[8'h22], usb_host_ee_model_inst.mem[8'h23]} = 16'h4100;
		{usb_host_ee_model_inst.mem[8'h24], usb_host_ee_model_inst.mem[8'h25]} = 16'h4200;
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_defaults();
		t_speeds();
		t_strings();
		end_of_test();
	end
endmodule // usb_desc_other_speed_bench
